//--- smq_matrix.sv
// Crossbar bus matrix with SRAM quality-of-service arbitration and its register slave.
`timescale 1ns/1ps
module smq_matrix import smq_pkg::*; #(
	parameter int DW = 32,
	parameter int AW = 32
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [N_MST-1:0] m_req,
	input wire logic [N_MST-1:0][2:0] m_sel,
	input wire logic [N_MST-1:0] m_we,
	input wire logic [N_MST-1:0][AW-1:0] m_addr,
	input wire logic [N_MST-1:0][DW-1:0] m_wdata,
	output logic [N_MST-1:0] m_gnt,
	output logic [N_MST-1:0] m_rvalid_q,
	output logic [N_MST-1:0][DW-1:0] m_rdata_q,
	output logic [N_BRG-1:0] s_valid_q,
	output logic [N_BRG-1:0] s_we_q,
	output logic [N_BRG-1:0][AW-1:0] s_addr_q,
	output logic [N_BRG-1:0][DW-1:0] s_wdata_q,
	output logic [N_BRG-1:0][1:0] s_mid_q,
	input wire logic [N_BRG-1:0][DW-1:0] s_rdata,
	input wire logic [N_DIR-1:0] d_req,
	input wire logic [N_DIR-1:0] d_we,
	input wire logic [N_DIR-1:0][AW-1:0] d_addr,
	input wire logic [N_DIR-1:0][DW-1:0] d_wdata,
	output logic [N_DIR-1:0] d_gnt,
	input wire logic [1:0] usb_qos,
	input wire logic [1:0] dma_wb_qos,
	input wire logic [1:0] dma_fetch_qos,
	input wire logic [1:0] dma_data_qos,
	output logic sram_valid_q,
	output logic [2:0] sram_port_q,
	output logic [1:0] sram_qos_q,
	output logic sram_we_q,
	output logic [AW-1:0] sram_addr_q,
	output logic [DW-1:0] sram_wdata_q,
	input wire logic [DW-1:0] sram_rdata,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	if (DW != 32) begin : g_dw_check
		$error("smq_matrix: DW must be 32");
	end
	if (AW < 2) begin : g_aw_check
		$error("smq_matrix: AW too small");
	end

	logic [1:0] cpu_qos_q;
	logic [N_SPORT-1:0] sreq;
	logic [N_SPORT-1:0] wait_q;
	logic [N_SPORT-1:0] elig;
	logic [N_SPORT-1:0][1:0] pqos;
	logic [N_SPORT-1:0] sgnt;
	logic sram_any;
	logic [2:0] win;
	logic [1:0] winq;
	logic [N_MST-1:0][2:0] mport;
	logic [N_MST-1:0] to_sram;
	logic [N_MST-1:0] pend_q;
	logic [N_MST-1:0] pend_sram_q;
	logic [N_MST-1:0][1:0] pend_slv_q;
	logic [2:0] last_port_q;
	logic [1:0] last_qos_q;

	// Fixed master numbering to SRAM port
	// Each master owns one matrix-side SRAM port
	assign mport[MST_CPU] = PORT_CPU;
	assign mport[MST_DEBUG] = PORT_DEBUG;
	assign mport[MST_DMA] = PORT_DMA_DATA;

	always_comb begin
		for (int m = 0; m < N_MST; m++) begin
			to_sram[m] = m_sel[m] >= SLV_SRAM_FIRST;
		end
		sreq = '0;
		sreq[N_DIR-1:0] = d_req;
		for (int m = 0; m < N_MST; m++) begin
			sreq[mport[m]] = m_req[m] & to_sram[m];
		end
	end

	// USB and DMA levels come from their masters
	// Trace and debug levels are fixed; the processor level comes from its register
	assign pqos[PORT_TRACE] = QOS_TRACE_FIXED;
	assign pqos[PORT_USB] = usb_qos;
	assign pqos[PORT_DMA_WB] = dma_wb_qos;
	assign pqos[PORT_DMA_FETCH] = dma_fetch_qos;
	assign pqos[PORT_CPU] = cpu_qos_q;
	assign pqos[PORT_DMA_DATA] = dma_data_qos;
	assign pqos[PORT_DEBUG] = QOS_DEBUG_FIXED;

	// Low levels must wait one cycle
	always_comb begin
		for (int p = 0; p < N_SPORT; p++) begin
			elig[p] = sreq[p] & ((pqos[p] >= QOS_LATENCY) | wait_q[p]);
		end
	end

	// A waiting port keeps its credit only while it still requests, so every new
	// low-level access pays the cycle again.
	always_ff @(posedge mclk) begin
		if (reset) begin
			wait_q <= '0;
		end else begin
			wait_q <= sreq & ~sgnt;
		end
	end

	// Level first, then lowest port number
	// Trace port wins ties with the processor
	always_comb begin
		sram_any = 1'b0;
		win = PORT_TRACE;
		winq = QOS_BACKGROUND;
		for (int p = 0; p < N_SPORT; p++) begin
			if (elig[p] && (!sram_any || pqos[p] > winq)) begin
				sram_any = 1'b1;
				win = 3'(p);
				winq = pqos[p];
			end
		end
		sgnt = '0;
		if (sram_any) begin
			sgnt[win] = 1'b1;
		end
	end

	assign d_gnt = sgnt[N_DIR-1:0];

	// Lowest master id wins a bridge slave
	always_comb begin
		for (int m = 0; m < N_MST; m++) begin
			if (to_sram[m]) begin
				m_gnt[m] = sgnt[mport[m]];
			end else begin
				m_gnt[m] = m_req[m];
				for (int o = 0; o < m; o++) begin
					if (m_req[o] && !to_sram[o] && m_sel[o] == m_sel[m]) begin
						m_gnt[m] = 1'b0;
					end
				end
			end
		end
	end

	// Access and its level go out together
	always_ff @(posedge mclk) begin
		if (reset) begin
			sram_valid_q <= 1'b0;
			sram_port_q <= PORT_TRACE;
			sram_qos_q <= QOS_BACKGROUND;
			sram_we_q <= 1'b0;
			sram_addr_q <= '0;
			sram_wdata_q <= '0;
		end else begin
			sram_valid_q <= sram_any;
			sram_port_q <= win;
			sram_qos_q <= winq;
			if (win < PORT_CPU) begin
				sram_we_q <= d_we[win[1:0]];
				sram_addr_q <= d_addr[win[1:0]];
				sram_wdata_q <= d_wdata[win[1:0]];
			end
			for (int m = 0; m < N_MST; m++) begin
				if (mport[m] == win) begin
					sram_we_q <= m_we[m];
					sram_addr_q <= m_addr[m];
					sram_wdata_q <= m_wdata[m];
				end
			end
		end
	end

	// Bridge and flash slaves driven in parallel
	for (genvar k = 0; k < N_BRG; k++) begin : g_slv
		always_ff @(posedge mclk) begin
			if (reset) begin
				s_valid_q[k] <= 1'b0;
				s_we_q[k] <= 1'b0;
				s_addr_q[k] <= '0;
				s_wdata_q[k] <= '0;
				s_mid_q[k] <= MST_CPU;
			end else begin
				s_valid_q[k] <= 1'b0;
				for (int m = 0; m < N_MST; m++) begin
					if (m_gnt[m] && !to_sram[m] && m_sel[m] == 3'(k)) begin
						s_valid_q[k] <= 1'b1;
						s_we_q[k] <= m_we[m];
						s_addr_q[k] <= m_addr[m];
						s_wdata_q[k] <= m_wdata[m];
						s_mid_q[k] <= 2'(m);
					end
				end
			end
		end
	end

	// Read data returns one cycle after the access leaves the matrix.
	for (genvar m = 0; m < N_MST; m++) begin : g_mst
		always_ff @(posedge mclk) begin
			if (reset) begin
				pend_q[m] <= 1'b0;
				pend_sram_q[m] <= 1'b0;
				pend_slv_q[m] <= SLV_FLASH[1:0];
				m_rvalid_q[m] <= 1'b0;
				m_rdata_q[m] <= '0;
			end else begin
				pend_q[m] <= m_gnt[m] & ~m_we[m];
				pend_sram_q[m] <= to_sram[m];
				pend_slv_q[m] <= m_sel[m][1:0];
				m_rvalid_q[m] <= pend_q[m];
				if (pend_q[m]) begin
					m_rdata_q[m] <= pend_sram_q[m] ? sram_rdata : s_rdata[pend_slv_q[m]];
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			last_port_q <= PORT_TRACE;
			last_qos_q <= QOS_BACKGROUND;
		end else if (sram_any) begin
			last_port_q <= win;
			last_qos_q <= winq;
		end
	end

	// Register slave. Address and data may arrive in either order.
	logic aw_q;
	logic w_q;
	logic [31:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;

	assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
	assign s_axi_wready = ~w_q & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;

	always_ff @(posedge mclk) begin
		if (reset) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (aw_q && w_q) begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_q == ADDR_CPU_QOS || awaddr_q == ADDR_STATUS) ?
					RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			cpu_qos_q <= CPU_QOS_RESET;
		end else if (aw_q && w_q && awaddr_q == ADDR_CPU_QOS && wstrb_q[0]) begin
			cpu_qos_q <= wdata_q[1:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			s_axi_rdata <= '0;
			if (s_axi_araddr == ADDR_CPU_QOS) begin
				s_axi_rdata[1:0] <= cpu_qos_q;
			end else if (s_axi_araddr == ADDR_STATUS) begin
				s_axi_rdata[STAT_PORT_LSB +: 3] <= last_port_q;
				s_axi_rdata[STAT_QOS_LSB +: 2] <= last_qos_q;
			end else begin
				s_axi_rresp <= RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule : smq_matrix

//--- smq_pkg.sv
// Shared constants for the SRAM bus matrix and its quality-of-service arbiter.
package smq_pkg;
	localparam int N_MST = 3;
	localparam int N_SLV = 7;
	localparam int N_BRG = 4;
	localparam int N_DIR = 4;
	localparam int N_SPORT = 7;
	localparam logic [2:0] SLV_FLASH = 3'h0;
	localparam logic [2:0] SLV_SRAM_FIRST = 3'h4;
	localparam logic [1:0] QOS_BACKGROUND = 2'h0;
	localparam logic [1:0] QOS_BANDWIDTH = 2'h1;
	localparam logic [1:0] QOS_LATENCY = 2'h2;
	localparam logic [1:0] QOS_CRITICAL = 2'h3;
	localparam logic [1:0] QOS_TRACE_FIXED = 2'h3;
	localparam logic [1:0] QOS_DEBUG_FIXED = 2'h1;
	localparam logic [1:0] MST_CPU = 2'h0;
	localparam logic [1:0] MST_DEBUG = 2'h1;
	localparam logic [1:0] MST_DMA = 2'h2;
	localparam logic [2:0] PORT_TRACE = 3'h0;
	localparam logic [2:0] PORT_USB = 3'h1;
	localparam logic [2:0] PORT_DMA_WB = 3'h2;
	localparam logic [2:0] PORT_DMA_FETCH = 3'h3;
	localparam logic [2:0] PORT_CPU = 3'h4;
	localparam logic [2:0] PORT_DMA_DATA = 3'h5;
	localparam logic [2:0] PORT_DEBUG = 3'h6;
	localparam logic [31:0] ADDR_CPU_QOS = 32'h41007110;
	localparam logic [31:0] ADDR_STATUS = 32'h41007114;
	localparam logic [1:0] CPU_QOS_RESET = 2'h0;
	localparam int STAT_PORT_LSB = 0;
	localparam int STAT_QOS_LSB = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : smq_pkg

//--- smq_sva.sv
// Port assertions for the SRAM bus matrix.
`timescale 1ns/1ps
module smq_sva import smq_pkg::*; (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [N_MST-1:0] m_req,
	input wire logic [N_MST-1:0][2:0] m_sel,
	input wire logic [N_MST-1:0] m_we,
	input wire logic [N_MST-1:0] m_gnt,
	input wire logic [N_MST-1:0] m_rvalid_q,
	input wire logic [N_BRG-1:0] s_valid_q,
	input wire logic [N_DIR-1:0] d_req,
	input wire logic [N_DIR-1:0] d_gnt,
	input wire logic sram_valid_q,
	input wire logic [2:0] sram_port_q,
	input wire logic [1:0] sram_qos_q
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);
	sequence s_rd;
		m_gnt[2] && !m_we[2] && m_sel[2] == 3'h2 ##1 s_valid_q[2];
	endsequence
	property p_gnt;
		(m_gnt & ~m_req) == 3'h0 && (d_gnt & ~d_req) == 4'h0;
	endproperty
	property p_one;
		$onehot0({d_gnt, m_gnt[0] && m_sel[0] > 3'h3, m_gnt[1] && m_sel[1] > 3'h3,
			m_gnt[2] && m_sel[2] > 3'h3});
	endproperty
	property p_brg;
		m_gnt[0] && m_sel[0] == 3'h1 |=> s_valid_q[1];
	endproperty
	property p_rd;
		s_rd |=> m_rvalid_q[2];
	endproperty
	property p_trace;
		d_gnt[0] |=> sram_valid_q && sram_port_q == PORT_TRACE && sram_qos_q == 2'h3;
	endproperty
	property p_first;
		d_req[0] |-> !(m_gnt[0] && m_sel[0] > 3'h3);
	endproperty
	property p_low;
		$rose(m_req[1]) && m_sel[1] > 3'h3 |-> !m_gnt[1];
	endproperty
	property p_dbg;
		m_gnt[1] && m_sel[1] > 3'h3 |=> sram_port_q == PORT_DEBUG && sram_qos_q == 2'h1;
	endproperty
	a_gnt: assert property (p_gnt) else $error("grant without request");
	a_one: assert property (p_one) else $error("two SRAM grants");
	a_brg: assert property (p_brg) else $error("bridge access lost");
	a_rd: assert property (p_rd) else $error("read data missing");
	a_trace: assert property (p_trace) else $error("trace access wrong");
	a_first: assert property (p_first) else $error("trace not first");
	a_low: assert property (p_low) else $error("low level not delayed");
	a_dbg: assert property (p_dbg) else $error("debug port wrong");
endmodule : smq_sva
bind smq_matrix smq_sva smq_sva_i (.*);

//--- smq_far.sv
// Far side model: zero-wait slaves and the levels of the USB and DMA masters.
`timescale 1ns/1ps
module smq_far import smq_pkg::*; (
	input wire logic [N_BRG-1:0] s_valid_q,
	input wire logic [N_BRG-1:0][31:0] s_addr_q,
	input wire logic sram_valid_q,
	input wire logic [31:0] sram_addr_q,
	output logic [N_BRG-1:0][31:0] s_rdata,
	output logic [31:0] sram_rdata,
	output logic [1:0] usb_qos,
	output logic [1:0] dma_wb_qos,
	output logic [1:0] dma_fetch_qos,
	output logic [1:0] dma_data_qos
);
	assign usb_qos = QOS_LATENCY;
	assign dma_wb_qos = QOS_LATENCY;
	assign dma_fetch_qos = QOS_CRITICAL;
	assign dma_data_qos = QOS_BANDWIDTH;
	// Data is inverted outside its cycle, so a late sample cannot match.
	always_comb begin
		for (int i = 0; i < N_BRG; i++) begin
			s_rdata[i] = s_valid_q[i] ? s_addr_q[i] ^ 32'h5A5A0000 : ~s_addr_q[i];
		end
		sram_rdata = sram_valid_q ? sram_addr_q : ~sram_addr_q;
	end
endmodule : smq_far

//--- testbench.sv
// Self-checking bench for the SRAM bus matrix.
`timescale 1ns/1ps
module testbench import smq_pkg::*;;
	logic mclk = 0, reset = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, sram_valid_q, sram_we_q;
	logic [N_MST-1:0] m_req = '0, m_we = '0, m_gnt, m_rvalid_q;
	logic [N_MST-1:0][2:0] m_sel = '0;
	logic [N_MST-1:0][31:0] m_addr = '0, m_wdata = '0, m_rdata_q;
	logic [N_BRG-1:0] s_valid_q, s_we_q;
	logic [N_BRG-1:0][31:0] s_addr_q, s_wdata_q, s_rdata;
	logic [N_BRG-1:0][1:0] s_mid_q;
	logic [N_DIR-1:0] d_req = '0, d_we = '0, d_gnt;
	logic [N_DIR-1:0][31:0] d_addr = '0, d_wdata = '0;
	logic [1:0] usb_qos, dma_wb_qos, dma_fetch_qos, dma_data_qos, sram_qos_q;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [2:0] sram_port_q;
	logic [31:0] sram_addr_q, sram_wdata_q, sram_rdata, s_axi_rdata;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
	logic [3:0] s_axi_wstrb = 4'h0;
	int err_count = 0, checks_done = 0;
	smq_matrix smq_matrix_i (.*);
	smq_far smq_far_i (.*);
	always #12.5 mclk = ~mclk;
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic tick(inout int k);
		if (++k > 50) begin
			err_count++;
			finish_test();
		end
		@(negedge mclk);
	endtask : tick
	task automatic axi_wr(logic [31:0] a, logic [31:0] d, output logic [1:0] r);
		int k = 0;
		bit da = 0, dw = 0;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'h1;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		while (!(da && dw)) begin
			tick(k);
			da |= s_axi_awready;
			dw |= s_axi_wready;
			@(posedge mclk);
			if (da) s_axi_awvalid <= 0;
			if (dw) s_axi_wvalid <= 0;
		end
		s_axi_bready <= 1;
		do tick(k); while (!s_axi_bvalid);
		r = s_axi_bresp;
		@(posedge mclk);
		s_axi_bready <= 0;
	endtask : axi_wr
	task automatic axi_rd(logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		int k = 0;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do tick(k); while (!s_axi_arready);
		@(posedge mclk);
		s_axi_arvalid <= 0;
		s_axi_rready <= 1;
		do tick(k); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		@(posedge mclk);
		s_axi_rready <= 0;
	endtask : axi_rd
	// Direct port when dir is set, else a matrix master; k counts refused cycles.
	task automatic acc(bit dir, int i, logic [2:0] sel, bit we, logic [31:0] a, output int k);
		@(posedge mclk);
		if (dir) begin
			{d_req[i], d_we[i], d_addr[i], d_wdata[i]} <= {1'b1, we, a, ~a};
		end else begin
			{m_req[i], m_we[i], m_sel[i], m_addr[i], m_wdata[i]} <= {1'b1, we, sel, a, ~a};
		end
		k = -1;
		do tick(k); while (!(dir ? d_gnt[i] : m_gnt[i]));
		@(posedge mclk);
		if (dir) d_req[i] <= 0;
		else m_req[i] <= 0;
	endtask : acc
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(ADDR_CPU_QOS, d, r);
		chk("level reset", d, 32'h0);
		axi_wr(ADDR_CPU_QOS, 32'h3, r);
		chk("write resp", r, RESP_OKAY);
		axi_rd(ADDR_CPU_QOS, d, r);
		chk("level", d, 32'h3);
		axi_rd(32'h41007200, d, r);
		chk("unmapped", r, RESP_SLVERR);
		$display("register test done");
	endtask : t_regs
	task automatic t_bus;
		int k0, k1;
		fork
			acc(0, 0, 3'h1, 0, 32'h100, k0);
			acc(0, 2, 3'h2, 0, 32'h200, k1);
		join
		chk("concurrent", k0 + k1, 0);
		@(negedge mclk);
		chk("bridges", s_valid_q, 4'h6);
		chk("dma id", s_mid_q[2], MST_DMA);
		@(negedge mclk);
		chk("rvalid", m_rvalid_q, 3'h5);
		chk("rdata", m_rdata_q[0], 32'h5A5A0100);
		chk("dma rdata", m_rdata_q[2], 32'h5A5A0200);
		fork
			acc(0, 0, 3'h3, 0, 32'h300, k0);
			acc(0, 1, 3'h3, 1, 32'h340, k1);
		join
		chk("contend", k1, 1);
		@(negedge mclk);
		chk("we", s_we_q[3], 1'b1);
		chk("mid", s_mid_q[3], MST_DEBUG);
		chk("addr", s_addr_q[3], 32'h340);
		chk("wdata", s_wdata_q[3], ~32'h340);
		$display("bus test done");
	endtask : t_bus
	task automatic t_sram;
		int k0, k1;
		logic [31:0] d;
		logic [1:0] r;
		fork
			acc(1, 0, 3'h0, 1, 32'h10, k0);
			acc(0, 0, 3'h4, 0, 32'h20, k1);
		join
		chk("trace first", k1, 1);
		@(negedge mclk);
		chk("cpu level", {sram_port_q, sram_qos_q}, {PORT_CPU, 2'h3});
		chk("cpu addr", sram_addr_q, 32'h20);
		fork
			acc(1, 1, 3'h0, 0, 32'h40, k0);
			acc(1, 2, 3'h0, 1, 32'h50, k1);
		join
		chk("port order", k1 - k0, 1);
		fork
			acc(1, 1, 3'h0, 0, 32'h80, k0);
			acc(1, 3, 3'h0, 0, 32'h90, k1);
		join
		chk("level first", k0, 1);
		chk("critical", k1, 0);
		acc(1, 2, 3'h0, 1, 32'hA0, k0);
		@(negedge mclk);
		chk("wb valid", sram_valid_q, 1'b1);
		chk("wb port", {sram_port_q, sram_qos_q}, {PORT_DMA_WB, QOS_LATENCY});
		chk("wb we", sram_we_q, 1'b1);
		chk("wb data", sram_wdata_q, ~32'hA0);
		acc(0, 1, 3'h6, 0, 32'h60, k0);
		chk("debug wait", k0 > 0, 1);
		axi_wr(ADDR_CPU_QOS, 32'h0, r);
		acc(0, 0, 3'h5, 0, 32'h70, k0);
		chk("cpu wait", k0 > 0, 1);
		@(negedge mclk);
		chk("cpu low", {sram_port_q, sram_qos_q}, {PORT_CPU, QOS_BACKGROUND});
		@(negedge mclk);
		chk("sram rdata", m_rdata_q[0], 32'h70);
		// Status holds the last granted port in its low bits and its level above.
		axi_rd(ADDR_STATUS, d, r);
		chk("status", d, 32'h4);
		$display("sram test done");
	endtask : t_sram
	initial begin
		repeat (20) @(posedge mclk);
		reset <= 0;
		t_regs();
		t_bus();
		t_sram();
		finish_test();
	end
endmodule : testbench
